// ===== sro_params.svh
`ifndef SRO_PARAMS_SVH
`define SRO_PARAMS_SVH

// Categories handled at once and the F_CTL flag position
`define NUM_CAT 4
`define FCTL_RO_BIT 3

// Register byte offsets; REG_RX_SPACE_HI is the high nibble of the RX space block
`define REG_CTRL 8'h00
`define REG_REMOTE_MODE 8'h04
`define REG_LOCAL_MODE 8'h08
`define REG_TX_CFG 8'h0c
`define REG_TX_INIT_RO 8'h10
`define REG_TX_UNIT_LEN 8'h14
`define REG_TX_SPACE 8'h18
`define REG_TX_PARAM 8'h1c
`define REG_RX_SPACE_HI 4'h2
`define REG_STATUS 8'h30
`define REG_COUNTS 8'h34

// Field positions
`define CTRL_TX_START 0
`define CTRL_RX_CLEAR 1
`define CTRL_TX_NEWSEQ 2
`define STAT_TX_BUSY 0
`define STAT_TX_ERR 1
`define STAT_SEQ_GAP 2
`define TX_MAXLEN_LSB 16

// Reset values
`define RST_MODES 8'h00
`define RST_MAXLEN 16'h0800
`define RST_SPACE 32'hffffffff

// Reject reason codes, values arbitrary
`define RJT_RO_NOT_SUP 8'h01
`define RJT_RO_OOB 8'h02
`define RJT_INV_PARAM 8'h03

`endif

// ===== sro_types_pkg.sv
package sro_types_pkg;

	typedef enum logic [1:0] {
		RO_NONE = 2'b00,
		RO_CONT = 2'b01,
		RO_RAND = 2'b10
	} ro_mode_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01,
		TX_WAIT = 2'b10
	} tx_state_t;

endpackage

// ===== ro_bound.sv
module ro_bound (
	input wire logic [31:0] offset,
	input wire logic [15:0] len,
	input wire logic [31:0] space,
	output logic fits
);

	// 33-bit sum so an offset near the top cannot wrap back into range
	assign fits = ({1'b0, offset} + {17'h0_0000, len}) <= {1'b0, space};

endmodule // ro_bound

// ===== sro_regs.sv
`include "sro_params.svh"

module sro_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic tx_start_p,
	output logic tx_newseq_p,
	output logic rx_clear_p,
	output logic [2:0] stat_clr_p,
	output logic [7:0] remote_modes,
	output logic [7:0] local_modes,
	output logic [1:0] tx_cat,
	output logic [15:0] tx_maxlen,
	output logic [31:0] tx_init_ro,
	output logic [31:0] tx_unit_len,
	output logic [31:0] tx_space,
	output logic [31:0] tx_param,
	output logic [3:0][31:0] rx_space,
	input wire logic [2:0] status,
	input wire logic [7:0] discard_cnt,
	input wire logic [15:0] prjt_cnt
);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
		end
		return r;
	endfunction

	logic wait_q;
	logic wr_ok;
	logic [31:0] rd_d;
	logic [31:0] cfg_w;
	logic [31:0] cfg_m;

	assign waitrequest = wait_q;
	// A write lands only on the edge where the master sees waitrequest low
	assign wr_ok = write && !wait_q;
	assign cfg_w = {tx_maxlen, 14'h0000, tx_cat};
	assign cfg_m = merge(cfg_w, writedata, byteenable);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) wait_q <= 1'b1;
		else wait_q <= !((read || write) && wait_q);
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (address == `REG_REMOTE_MODE) rd_d = {24'h00_0000, remote_modes};
		else if (address == `REG_LOCAL_MODE) rd_d = {24'h00_0000, local_modes};
		else if (address == `REG_TX_CFG) rd_d = cfg_w;
		else if (address == `REG_TX_INIT_RO) rd_d = tx_init_ro;
		else if (address == `REG_TX_UNIT_LEN) rd_d = tx_unit_len;
		else if (address == `REG_TX_SPACE) rd_d = tx_space;
		else if (address == `REG_TX_PARAM) rd_d = tx_param;
		else if (address[7:4] == `REG_RX_SPACE_HI) rd_d = rx_space[address[3:2]];
		else if (address == `REG_STATUS) rd_d = {29'h0000_0000, status};
		else if (address == `REG_COUNTS) rd_d = {prjt_cnt, 8'h00, discard_cnt};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) readdata <= 32'h0000_0000;
		else if (read && wait_q) readdata <= rd_d;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remote_modes <= `RST_MODES;
			local_modes <= `RST_MODES;
			tx_cat <= 2'h0;
			tx_maxlen <= `RST_MAXLEN;
			tx_init_ro <= 32'h0000_0000;
			tx_unit_len <= 32'h0000_0000;
			tx_space <= `RST_SPACE;
			tx_param <= 32'h0000_0000;
			rx_space <= {4{`RST_SPACE}};
		end else if (wr_ok) begin
			if (address == `REG_REMOTE_MODE) begin
				remote_modes <= writedata[7:0];
			end else if (address == `REG_LOCAL_MODE) begin
				local_modes <= writedata[7:0];
			end else if (address == `REG_TX_CFG) begin
				tx_maxlen <= cfg_m[31:16];
				tx_cat <= cfg_m[1:0];
			end else if (address == `REG_TX_INIT_RO) begin
				tx_init_ro <= merge(tx_init_ro, writedata, byteenable);
			end else if (address == `REG_TX_UNIT_LEN) begin
				tx_unit_len <= merge(tx_unit_len, writedata, byteenable);
			end else if (address == `REG_TX_SPACE) begin
				tx_space <= merge(tx_space, writedata, byteenable);
			end else if (address == `REG_TX_PARAM) begin
				tx_param <= merge(tx_param, writedata, byteenable);
			end else if (address[7:4] == `REG_RX_SPACE_HI) begin
				rx_space[address[3:2]] <= merge(rx_space[address[3:2]],
					writedata, byteenable);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_start_p <= 1'b0;
			tx_newseq_p <= 1'b0;
			rx_clear_p <= 1'b0;
			stat_clr_p <= 3'h0;
		end else begin
			tx_start_p <= wr_ok && address == `REG_CTRL && byteenable[0]
				&& writedata[`CTRL_TX_START];
			tx_newseq_p <= wr_ok && address == `REG_CTRL && byteenable[0]
				&& writedata[`CTRL_TX_NEWSEQ];
			rx_clear_p <= wr_ok && address == `REG_CTRL && byteenable[0]
				&& writedata[`CTRL_RX_CLEAR];
			stat_clr_p <= (wr_ok && address == `REG_STATUS && byteenable[0])
				? writedata[2:0] : 3'h0;
		end
	end

endmodule // sro_regs

// ===== seg_reasm.sv
// Register access over Avalon-MM and the register addresses were left to the implementer.
`include "sro_params.svh"


module seg_reasm (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic TX_VALID,
	input wire logic TX_READY,
	output logic [1:0] TX_CAT,
	output logic TX_RO_PRESENT,
	output logic [31:0] TX_PARAM,
	output logic [15:0] TX_SEQ_CNT,
	output logic [15:0] TX_LEN,
	output logic TX_LAST,
	input wire logic RX_VALID,
	input wire logic RX_NEW_SEQ,
	input wire logic [1:0] RX_CAT,
	input wire logic [23:0] RX_F_CTL,
	input wire logic [31:0] RX_PARAM,
	input wire logic [15:0] RX_SEQ_CNT,
	input wire logic [15:0] RX_LEN,
	input wire logic RX_ACK_CLASS,
	output logic RX_PLACE_VALID,
	output logic [1:0] RX_PLACE_CAT,
	output logic [31:0] RX_PLACE_OFFSET,
	output logic [15:0] RX_PLACE_LEN,
	output logic RX_DISCARD,
	output logic RX_PRJT_VALID,
	output logic [7:0] RX_PRJT_REASON
);

	logic tx_start_p, tx_newseq_p, rx_clear_p;
	logic [2:0] stat_clr_p;
	logic [7:0] remote_modes, local_modes;
	logic [1:0] cfg_cat;
	logic [15:0] cfg_maxlen;
	logic [31:0] cfg_init_ro, cfg_unit_len, cfg_space, cfg_param;
	logic [3:0][31:0] rx_space;
	logic tx_err_q, seq_gap_q;
	logic [7:0] discard_cnt_q;
	logic [15:0] prjt_cnt_q;
	sro_types_pkg::tx_state_t state_q;

	sro_regs u_regs (
		.clk(CLK),
		.rst(RST),
		.address(AVS_ADDRESS),
		.read(AVS_READ),
		.write(AVS_WRITE),
		.writedata(AVS_WRITEDATA),
		.byteenable(AVS_BYTEENABLE),
		.readdata(AVS_READDATA),
		.waitrequest(AVS_WAITREQUEST),
		.tx_start_p(tx_start_p),
		.tx_newseq_p(tx_newseq_p),
		.rx_clear_p(rx_clear_p),
		.stat_clr_p(stat_clr_p),
		.remote_modes(remote_modes),
		.local_modes(local_modes),
		.tx_cat(cfg_cat),
		.tx_maxlen(cfg_maxlen),
		.tx_init_ro(cfg_init_ro),
		.tx_unit_len(cfg_unit_len),
		.tx_space(cfg_space),
		.tx_param(cfg_param),
		.rx_space(rx_space),
		.status({seq_gap_q, tx_err_q, state_q != sro_types_pkg::TX_IDLE}),
		.discard_cnt(discard_cnt_q),
		.prjt_cnt(prjt_cnt_q)
	);

	// ---------------- Segmentation ----------------

	sro_types_pkg::ro_mode_t mode_q;
	logic [1:0] cat_q;
	logic [31:0] ro_q, rem_q, unit_init_q, space_q, param_q;
	logic [15:0] maxlen_q, seq_q, len_w;
	logic first_q, valid_q, tx_fit;

	// Frame size is the smaller of what remains and the payload limit
	assign len_w = (rem_q > {16'h0000, maxlen_q}) ? maxlen_q : rem_q[15:0];

	ro_bound u_tx_bound (
		.offset(ro_q),
		.len(len_w),
		.space(space_q),
		.fits(tx_fit)
	);

	// Unit settings are latched at start so software may stage the next unit
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q <= sro_types_pkg::TX_IDLE;
			mode_q <= sro_types_pkg::RO_NONE;
			cat_q <= 2'h0;
			ro_q <= 32'h0000_0000;
			rem_q <= 32'h0000_0000;
			unit_init_q <= 32'h0000_0000;
			space_q <= 32'h0000_0000;
			param_q <= 32'h0000_0000;
			maxlen_q <= 16'h0000;
			first_q <= 1'b0;
		end else begin
			case (state_q)
				sro_types_pkg::TX_IDLE: begin
					if (tx_start_p) begin
						// Fresh offset state per unit, any start offset taken
						cat_q <= cfg_cat;
						mode_q <= sro_types_pkg::ro_mode_t'(remote_modes[2*cfg_cat +: 2]);
						ro_q <= cfg_init_ro;
						unit_init_q <= cfg_init_ro;
						rem_q <= cfg_unit_len;
						space_q <= cfg_space;
						param_q <= cfg_param;
						maxlen_q <= cfg_maxlen;
						first_q <= 1'b1;
						state_q <= sro_types_pkg::TX_SEND;
					end
				end
				sro_types_pkg::TX_SEND: begin
					if (rem_q == 32'h0000_0000 || maxlen_q == 16'h0000) begin
						state_q <= sro_types_pkg::TX_IDLE;
					end else if (mode_q != sro_types_pkg::RO_NONE && !tx_fit) begin
						state_q <= sro_types_pkg::TX_IDLE;
					end else begin
						state_q <= sro_types_pkg::TX_WAIT;
					end
				end
				sro_types_pkg::TX_WAIT: begin
					if (TX_READY) begin
						// Offset advances by the payload just sent
						ro_q <= ro_q + {16'h0000, TX_LEN};
						rem_q <= rem_q - {16'h0000, TX_LEN};
						first_q <= 1'b0;
						state_q <= sro_types_pkg::TX_SEND;
					end
				end
				default: state_q <= sro_types_pkg::TX_IDLE;
			endcase
		end
	end

	// Count keeps running across units until software opens a new Sequence
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) seq_q <= 16'h0000;
		else if (tx_newseq_p && state_q == sro_types_pkg::TX_IDLE) seq_q <= 16'h0000;
		else if (state_q == sro_types_pkg::TX_WAIT && TX_READY) seq_q <= seq_q + 16'h0001;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			valid_q <= 1'b0;
			TX_CAT <= 2'h0;
			TX_RO_PRESENT <= 1'b0;
			TX_PARAM <= 32'h0000_0000;
			TX_LEN <= 16'h0000;
			TX_LAST <= 1'b0;
		end else if (state_q == sro_types_pkg::TX_SEND && rem_q != 32'h0000_0000
			&& maxlen_q != 16'h0000
			&& (mode_q == sro_types_pkg::RO_NONE || tx_fit)) begin
			valid_q <= 1'b1;
			TX_CAT <= cat_q;
			TX_LEN <= len_w;
			TX_LAST <= rem_q <= {16'h0000, maxlen_q};
			if (mode_q == sro_types_pkg::RO_NONE) begin
				TX_RO_PRESENT <= 1'b0;
				TX_PARAM <= param_q;
			end else begin
				TX_RO_PRESENT <= 1'b1;
				TX_PARAM <= ro_q;
			end
		end else if (state_q == sro_types_pkg::TX_WAIT && TX_READY) begin
			valid_q <= 1'b0;
		end
	end

	assign TX_VALID = valid_q;
	assign TX_SEQ_CNT = seq_q;

	// A unit that would leave its offset space stops and is flagged
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) tx_err_q <= 1'b0;
		else if (state_q == sro_types_pkg::TX_SEND && rem_q != 32'h0000_0000
			&& (maxlen_q == 16'h0000
			|| (mode_q != sro_types_pkg::RO_NONE && !tx_fit))) tx_err_q <= 1'b1;
		else if (stat_clr_p[`STAT_TX_ERR]) tx_err_q <= 1'b0;
	end

	AST_NOSUP_FLAG: assert property (@(posedge CLK) disable iff (RST)
		TX_VALID && mode_q == sro_types_pkg::RO_NONE
		|-> !TX_RO_PRESENT && TX_PARAM == param_q)
		else $error("offset flag set for a category without offset support");

	AST_RO_FLAG: assert property (@(posedge CLK) disable iff (RST)
		TX_VALID && mode_q != sro_types_pkg::RO_NONE |-> TX_RO_PRESENT)
		else $error("offset flag clear in an offset mode");

	AST_FIRST_RO: assert property (@(posedge CLK) disable iff (RST)
		TX_VALID && first_q && TX_RO_PRESENT |-> TX_PARAM == unit_init_q)
		else $error("first frame does not carry the start offset");

	AST_CONT_RO: assert property (@(posedge CLK) disable iff (RST)
		TX_VALID && TX_READY && !TX_LAST && mode_q == sro_types_pkg::RO_CONT
		|-> ##2 (!TX_VALID
		|| TX_PARAM == $past(TX_PARAM, 2) + {16'h0000, $past(TX_LEN, 2)}))
		else $error("offset of next frame is not continuous");

	AST_TX_SPACE: assert property (@(posedge CLK) disable iff (RST)
		TX_VALID && TX_RO_PRESENT
		|-> ({1'b0, TX_PARAM} + {17'h0_0000, TX_LEN}) <= {1'b0, space_q})
		else $error("frame leaves the offset space");

	// ---------------- Reassembly ----------------

	logic [31:0] exp_q [`NUM_CAT];
	logic [31:0] seqpos_q [`NUM_CAT];
	logic [15:0] lastseq_q [`NUM_CAT];
	logic [`NUM_CAT-1:0] started_q, seqseen_q;
	sro_types_pkg::ro_mode_t lmode;
	logic ro_flag, started_eff, seqseen_eff, rx_fit;
	logic act_seq, act_ro, drop, rjt;
	logic [7:0] reason;
	logic [31:0] seqpos_eff;

	assign ro_flag = RX_F_CTL[`FCTL_RO_BIT];
	assign lmode = sro_types_pkg::ro_mode_t'(local_modes[2*RX_CAT +: 2]);
	// The first frame of a new Sequence sees its own category fresh
	assign started_eff = started_q[RX_CAT] && !RX_NEW_SEQ;
	assign seqseen_eff = seqseen_q[RX_CAT] && !RX_NEW_SEQ;
	assign seqpos_eff = RX_NEW_SEQ ? 32'h0000_0000 : seqpos_q[RX_CAT];

	ro_bound u_rx_bound (
		.offset(RX_PARAM),
		.len(RX_LEN),
		.space(rx_space[RX_CAT]),
		.fits(rx_fit)
	);

	always_comb begin
		act_seq = 1'b0;
		act_ro = 1'b0;
		drop = 1'b0;
		rjt = 1'b0;
		reason = 8'h00;
		if (!ro_flag) begin
			act_seq = 1'b1;
		end else if (lmode == sro_types_pkg::RO_NONE) begin
			drop = 1'b1;
			rjt = RX_ACK_CLASS;
			reason = `RJT_RO_NOT_SUP;
		end else if (!rx_fit) begin
			drop = 1'b1;
			rjt = 1'b1;
			reason = `RJT_INV_PARAM;
		end else if (lmode == sro_types_pkg::RO_CONT && started_eff
			&& RX_PARAM != exp_q[RX_CAT]) begin
			drop = 1'b1;
			rjt = RX_ACK_CLASS;
			reason = `RJT_RO_OOB;
		end else begin
			act_ro = 1'b1;
		end
	end

	// One state slice per category; a new-Sequence frame on any category clears the other categories' state
	for (genvar g = 0; g < `NUM_CAT; g++) begin : g_cat
		always_ff @(posedge CLK or posedge RST) begin
			if (RST) begin
				exp_q[g] <= 32'h0000_0000;
				seqpos_q[g] <= 32'h0000_0000;
				lastseq_q[g] <= 16'h0000;
				started_q[g] <= 1'b0;
				seqseen_q[g] <= 1'b0;
			end else if (rx_clear_p || (RX_VALID && RX_NEW_SEQ
				&& RX_CAT != 2'(g))) begin
				seqpos_q[g] <= 32'h0000_0000;
				started_q[g] <= 1'b0;
				seqseen_q[g] <= 1'b0;
			end else if (RX_VALID && RX_CAT == 2'(g)) begin
				started_q[g] <= act_ro || started_eff;
				seqseen_q[g] <= act_seq || seqseen_eff;
				seqpos_q[g] <= act_seq ? seqpos_eff + {16'h0000, RX_LEN}
					: seqpos_eff;
				if (act_seq) lastseq_q[g] <= RX_SEQ_CNT;
				if (act_ro) exp_q[g] <= RX_PARAM + {16'h0000, RX_LEN};
			end
		end
	end

	// Payload itself is out of band; only the placement is produced here
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			RX_PLACE_VALID <= 1'b0;
			RX_PLACE_CAT <= 2'h0;
			RX_PLACE_OFFSET <= 32'h0000_0000;
			RX_PLACE_LEN <= 16'h0000;
			RX_DISCARD <= 1'b0;
			RX_PRJT_VALID <= 1'b0;
			RX_PRJT_REASON <= 8'h00;
		end else begin
			RX_PLACE_VALID <= RX_VALID && (act_seq || act_ro);
			RX_DISCARD <= RX_VALID && drop;
			RX_PRJT_VALID <= RX_VALID && rjt;
			if (RX_VALID) begin
				RX_PLACE_CAT <= RX_CAT;
				RX_PLACE_LEN <= RX_LEN;
				RX_PLACE_OFFSET <= act_ro ? RX_PARAM : seqpos_eff;
				RX_PRJT_REASON <= reason;
			end
		end
	end

	// Counts wrap modulo 65536, so FFFFh followed by 0000h is no gap
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) seq_gap_q <= 1'b0;
		else if (RX_VALID && act_seq && seqseen_eff
			&& RX_SEQ_CNT != lastseq_q[RX_CAT] + 16'h0001) seq_gap_q <= 1'b1;
		else if (stat_clr_p[`STAT_SEQ_GAP]) seq_gap_q <= 1'b0;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			discard_cnt_q <= 8'h00;
			prjt_cnt_q <= 16'h0000;
		end else if (rx_clear_p) begin
			discard_cnt_q <= 8'h00;
			prjt_cnt_q <= 16'h0000;
		end else begin
			if (RX_VALID && drop) discard_cnt_q <= discard_cnt_q + 8'h01;
			if (RX_VALID && rjt) prjt_cnt_q <= prjt_cnt_q + 16'h0001;
		end
	end

	AST_NOSUP_DISCARD: assert property (@(posedge CLK) disable iff (RST)
		RX_VALID && ro_flag && lmode == sro_types_pkg::RO_NONE
		|=> RX_DISCARD && !RX_PLACE_VALID && RX_PRJT_VALID == $past(RX_ACK_CLASS)
		&& (!RX_PRJT_VALID || RX_PRJT_REASON == `RJT_RO_NOT_SUP))
		else $error("unsupported offset frame not discarded correctly");

	AST_SEQ_PLACE: assert property (@(posedge CLK) disable iff (RST)
		RX_VALID && !ro_flag
		|=> RX_PLACE_VALID && !RX_DISCARD && RX_PLACE_OFFSET == $past(seqpos_eff))
		else $error("flag-clear frame not placed by count");

	AST_SEQ_CHAIN: assert property (@(posedge CLK) disable iff (RST)
		RX_VALID && !ro_flag ##1 RX_VALID && !ro_flag && !RX_NEW_SEQ
		&& RX_CAT == $past(RX_CAT)
		|=> RX_PLACE_OFFSET == $past(RX_PLACE_OFFSET) + {16'h0000, $past(RX_PLACE_LEN)})
		else $error("count placement does not follow previous frame");

	AST_RO_PLACE: assert property (@(posedge CLK) disable iff (RST)
		RX_VALID && ro_flag && rx_fit && lmode != sro_types_pkg::RO_NONE
		&& lmode != sro_types_pkg::RO_CONT
		|=> RX_PLACE_VALID && RX_PLACE_OFFSET == $past(RX_PARAM))
		else $error("offset frame not placed at its offset");

	AST_OOB_REJECT: assert property (@(posedge CLK) disable iff (RST)
		RX_VALID && ro_flag && rx_fit && lmode == sro_types_pkg::RO_CONT
		&& started_eff && RX_PARAM != exp_q[RX_CAT] && RX_ACK_CLASS
		|=> RX_DISCARD && RX_PRJT_VALID && RX_PRJT_REASON == `RJT_RO_OOB)
		else $error("discontinuous offset not rejected");

	AST_INV_PARAM: assert property (@(posedge CLK) disable iff (RST)
		RX_VALID && ro_flag && !rx_fit && lmode != sro_types_pkg::RO_NONE
		|=> RX_PRJT_VALID && RX_PRJT_REASON == `RJT_INV_PARAM && !RX_PLACE_VALID)
		else $error("out of bounds offset not rejected");

endmodule // seg_reasm

// ===== remote_port.sv
module remote_port (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic tx_ro,
	input wire logic [31:0] tx_param,
	input wire logic [15:0] tx_cnt,
	input wire logic [15:0] tx_len,
	input wire logic tx_last,
	output int n_frames
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] f_param [0:15];
	logic [15:0] f_len [0:15];
	logic [15:0] f_cnt [0:15];
	logic [1:0] f_flags [0:15];
	// Stalling every other cycle proves the sender holds a frame until taken
	always_ff @(posedge clk or posedge rst) begin
		if (rst) tx_ready <= 1'b0;
		else tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) n_frames <= 0;
		else if (tx_valid && tx_ready && n_frames < 16) begin
			f_param[n_frames] <= tx_param;
			f_len[n_frames] <= tx_len;
			f_cnt[n_frames] <= tx_cnt;
			f_flags[n_frames] <= {tx_ro, tx_last};
			n_frames <= n_frames + 1;
		end
	end
endmodule // remote_port

// ===== testbench.sv
`include "sro_params.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, rd, wr, wq, slow, txv, txr, ro, last;
	logic [7:0] adr, reason;
	logic [31:0] wd, rdat, txp, q;
	logic [15:0] cnt, len;
	logic [1:0] tcat;
	logic rv, rnew, rack, pv, disc, pj;
	logic [1:0] rcat, pcat;
	logic [23:0] fctl;
	logic [31:0] rpar, poff;
	logic [15:0] rcnt, rlen, plen;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;
	int nf;
	seg_reasm dut (.CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .TX_VALID(txv),
		.TX_READY(txr), .TX_CAT(tcat), .TX_RO_PRESENT(ro), .TX_PARAM(txp),
		.TX_SEQ_CNT(cnt), .TX_LEN(len), .TX_LAST(last), .RX_VALID(rv),
		.RX_NEW_SEQ(rnew), .RX_CAT(rcat), .RX_F_CTL(fctl), .RX_PARAM(rpar),
		.RX_SEQ_CNT(rcnt), .RX_LEN(rlen), .RX_ACK_CLASS(rack),
		.RX_PLACE_VALID(pv), .RX_PLACE_CAT(pcat), .RX_PLACE_OFFSET(poff),
		.RX_PLACE_LEN(plen), .RX_DISCARD(disc), .RX_PRJT_VALID(pj),
		.RX_PRJT_REASON(reason));
	remote_port rp (.clk(clk), .rst(rst), .slow(slow), .tx_valid(txv),
		.tx_ready(txr), .tx_ro(ro), .tx_param(txp), .tx_cnt(cnt),
		.tx_len(len), .tx_last(last), .n_frames(nf));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		// Whole run needs well under a thousand cycles
		if (cycles == 5000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= ~w;
		wd <= d;
		do @(posedge clk); while (wq);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic frames(input int k);
		int n;
		n = 0;
		while (nf < k && n < 400) begin
			@(posedge clk);
			n++;
		end
	endtask
	// A nonzero reason means the frame must be dropped
	task automatic rxf(input logic nw, input logic [1:0] c, input logic f,
		input logic [31:0] p, input logic [15:0] sc, input logic [15:0] ln,
		input logic ack, input logic [7:0] rs, input logic [31:0] off);
		logic ej;
		ej = (rs != 8'h00) && (ack || rs == `RJT_INV_PARAM);
		@(posedge clk);
		rv <= 1'b1;
		rnew <= nw;
		rcat <= c;
		fctl <= {20'h0, f, 3'h0};
		rpar <= p;
		rcnt <= sc;
		rlen <= ln;
		rack <= ack;
		@(posedge clk);
		rv <= 1'b0;
		#1;
		chk({29'h0, pv, disc, pj}, {29'h0, rs == 8'h00, rs != 8'h00, ej});
		if (rs == 8'h00) chk({14'h0, pcat, plen}, {14'h0, c, ln});
		if (rs == 8'h00) chk(poff, off);
		if (ej) chk({24'h0, reason}, {24'h0, rs});
	endtask
	logic [31:0] e_par [0:5] = '{32'h100, 32'h110, 32'h120, 32'h0,
		32'h5a5a1234, 32'h5a5a1234};
	logic [15:0] e_len [0:5] = '{16'h10, 16'h10, 16'h8, 16'h10, 16'h10, 16'h4};
	logic [1:0] e_fl [0:5] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h1};
	initial begin
		{rst, rd, wr, slow, rv, rnew, rack} = 7'h40;
		{adr, wd, rcat, fctl, rpar, rcnt, rlen} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		bus(0, `REG_TX_CFG, 0);
		chk(q, 32'h08000000);
		bus(0, 8'h20, 0);
		chk(q, `RST_SPACE);
		bus(0, 8'h3c, 0);
		chk(q, 32'h0);
		slow <= 1'b1;
		bus(1, `REG_REMOTE_MODE, 32'h1);
		bus(1, `REG_TX_CFG, 32'h00100000);
		bus(1, `REG_TX_INIT_RO, 32'h100);
		bus(1, `REG_TX_UNIT_LEN, 32'd40);
		bus(1, `REG_CTRL, 32'h4);
		bus(1, `REG_CTRL, 32'h1);
		frames(3);
		slow <= 1'b0;
		bus(1, `REG_REMOTE_MODE, 32'h2);
		bus(1, `REG_TX_INIT_RO, 32'h0);
		bus(1, `REG_TX_UNIT_LEN, 32'd16);
		bus(1, `REG_CTRL, 32'h1);
		frames(4);
		bus(1, `REG_REMOTE_MODE, 32'h0);
		bus(1, `REG_TX_CFG, 32'h00100001);
		bus(1, `REG_TX_PARAM, 32'h5a5a1234);
		bus(1, `REG_TX_UNIT_LEN, 32'd20);
		bus(1, `REG_CTRL, 32'h1);
		frames(6);
		chk(nf, 6);
		for (int i = 0; i < 6; i++) begin
			chk(rp.f_param[i], e_par[i]);
			chk({rp.f_flags[i], rp.f_len[i]}, {e_fl[i], e_len[i]});
			chk(rp.f_cnt[i], i);
		end
		chk({30'h0, tcat}, 32'h1);
		bus(1, `REG_REMOTE_MODE, 32'h8);
		bus(1, `REG_TX_SPACE, 32'h8);
		bus(1, `REG_CTRL, 32'h1);
		repeat (4) @(posedge clk);
		bus(0, `REG_STATUS, 0);
		chk(q, 32'h2);
		chk(nf, 6);
		bus(1, `REG_STATUS, 32'h2);
		bus(0, `REG_STATUS, 0);
		chk(q, 32'h0);
		bus(1, `REG_LOCAL_MODE, 32'h24);
		bus(1, 8'h28, 32'h300);
		rxf(1, 0, 0, 32'hffff0000, 0, 10, 1, 0, 0);
		rxf(0, 1, 1, 32'h40, 1, 8, 1, 0, 32'h40);
		rxf(0, 0, 0, 32'h77, 2, 6, 1, 0, 10);
		rxf(0, 0, 1, 0, 3, 4, 1, `RJT_RO_NOT_SUP, 0);
		rxf(0, 0, 1, 0, 4, 4, 0, `RJT_RO_NOT_SUP, 0);
		rxf(0, 1, 1, 32'h48, 5, 8, 1, 0, 32'h48);
		rxf(0, 1, 1, 32'h60, 6, 8, 1, `RJT_RO_OOB, 0);
		rxf(0, 2, 1, 32'h200, 7, 16, 0, 0, 32'h200);
		rxf(0, 2, 1, 32'h100, 8, 16, 0, 0, 32'h100);
		rxf(0, 2, 1, 32'h2f8, 9, 16, 0, `RJT_INV_PARAM, 0);
		rxf(0, 3, 0, 0, 16'hffff, 5, 1, 0, 0);
		rxf(0, 3, 0, 0, 16'h0000, 7, 1, 0, 5);
		// Back to back count-placed frames of one category
		@(posedge clk);
		{rv, rcat, fctl, rcnt, rlen} <= {1'b1, 2'h3, 24'h0, 16'h1, 16'h3};
		@(posedge clk);
		rcnt <= 16'h2;
		rlen <= 16'h2;
		#1 chk(poff, 32'hc);
		@(posedge clk);
		rv <= 1'b0;
		#1 chk(poff, 32'hf);
		bus(0, `REG_COUNTS, 0);
		chk(q, 32'h00030004);
		wrap_up();
	end
endmodule // testbench
